// [common/mcs_map.svh]
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
`define MCS_CMD_RESET   6'h00
`define MCS_CMD_INIT    6'h01
`define MCS_CMD_CSD     6'h09
`define MCS_CMD_CID     6'h0A
`define MCS_CMD_STATUS  6'h0D
`define MCS_CMD_BLKLEN  6'h10
`define MCS_CMD_READ    6'h11
`define MCS_CMD_WRITE   6'h18
`define MCS_CMD_SETWP   6'h1C
`define MCS_CMD_CLRWP   6'h1D
`define MCS_CMD_ERASE   6'h26
`define MCS_CMD_CRCTOG  6'h3B
`define MCS_TOK_START   8'hFE
`define MCS_TOK_DERR    8'h01
`define MCS_DRESP_OK    8'h05
`define MCS_DRESP_CRC   8'h0B
`define MCS_DRESP_WERR  8'h0D
`define MCS_BYTE_IDLE   8'hFF
`define MCS_BYTE_BUSY   8'h00
`define MCS_R1_IDLE     0
`define MCS_R1_ILLEGAL  2
`define MCS_R1_CRC      3
`define MCS_R1_ADDR     5
`define MCS_R1_PARAM    6
`define MCS_BLK_MAX     10'd512
`define MCS_REG_LEN     10'd16
`define MCS_INIT_POLLS  2'd2
`define MCS_CMD_LAST    3'd5
`define MCS_POLY7       7'h09
`define MCS_POLY16      16'h1021
`endif

// [common/mcs_pkg.sv]
package mcs_pkg;
  typedef enum logic [2:0] {
    OP_READ, OP_CSD, OP_CID, OP_WRITE, OP_ABORT, OP_CMD
  } mcs_op_t;
  typedef enum {
    ST_CMD, ST_R2, ST_RD_WAIT, ST_RD_DATA, ST_RD_CRC1, ST_RD_CRC2,
    ST_WR_TOKEN, ST_WR_DATA, ST_WR_CRC1, ST_WR_CRC2, ST_RESP_BUSY, ST_BUSY
  } mcs_state_t;
  typedef struct packed {
    mcs_op_t     op;
    logic [5:0]  idx;
    logic [31:0] arg;
    logic [9:0]  len;
  } mcs_req_t;
  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } mcs_rd_t;
endpackage

// [logic/mcs_spi_card.sv]
`timescale 1ns/1ns
`include "mcs_map.svh"
module mcs_spi_card
  import mcs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       sclk,
  input  wire logic       selN,
  input  wire logic       cardSerialIn,
  output logic            cardSerialOut_ff,
  output logic            cardSerialOutOe_ff,
  input  wire mcs_rd_t    rdEntry,
  input  wire logic       rdValid,
  output logic            rdReady_ff,
  output mcs_req_t        req_ff,
  output logic            reqValid_ff,
  output logic [7:0]      wrData_ff,
  output logic            wrValid_ff,
  input  wire logic       memBusy,
  input  wire logic [7:0] cardStatus
);
  function automatic logic [6:0] crc7Byte(input logic [6:0] c, input logic [7:0] b);
    logic fb;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[6] ^ b[i];
      c = {c[5:0], 1'b0} ^ (fb ? `MCS_POLY7 : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [15:0] crc16Byte(input logic [15:0] c, input logic [7:0] b);
    logic fb;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? `MCS_POLY16 : 16'h0000);
    end
    return c;
  endfunction

  function automatic logic cmdLegal(input logic [5:0] i);
    case (i)
      6'h00, 6'h01, 6'h09, 6'h0A, 6'h0D, 6'h10, 6'h11, 6'h18, 6'h1B, 6'h1C,
      6'h1D, 6'h1E, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h2A,
      6'h3A, 6'h3B: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Pin synchronisers: {sclk, select, data}
  logic [2:0] syn1_ff, syn2_ff, syn3_ff, filt_ff, filtD_ff, nxtFilt;
  always_comb begin
    nxtFilt = (syn2_ff & ~(syn2_ff ^ syn3_ff)) | (filt_ff & (syn2_ff ^ syn3_ff));
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syn1_ff  <= 3'h2;
      syn2_ff  <= 3'h2;
      syn3_ff  <= 3'h2;
      filt_ff  <= 3'h2;
      filtD_ff <= 3'h2;
    end else begin
      syn1_ff  <= {sclk, selN, cardSerialIn};
      syn2_ff  <= syn1_ff;
      syn3_ff  <= syn2_ff;
      filt_ff  <= nxtFilt;
      filtD_ff <= filt_ff;
    end
  end

  logic csLow, csFall, rise, fall, mosiF;
  assign csLow  = !filt_ff[1];
  assign csFall = !filt_ff[1] && filtD_ff[1];
  assign rise   = filt_ff[2] && !filtD_ff[2];
  assign fall   = !filt_ff[2] && filtD_ff[2];
  assign mosiF  = filt_ff[0];

  // Two-entry read buffer between store and link
  mcs_rd_t    buf_ff [2];
  mcs_rd_t    nxtBuf [2];
  logic       wrPtr_ff, rdPtr_ff, nxtWrPtr, nxtRdPtr, pop, push;
  logic [1:0] cnt_ff, nxtCnt;
  mcs_rd_t    head;
  assign head = buf_ff[rdPtr_ff];
  assign push = rdValid && rdReady_ff;
  always_comb begin
    nxtBuf   = buf_ff;
    nxtWrPtr = wrPtr_ff;
    nxtRdPtr = rdPtr_ff;
    if (push) begin
      nxtBuf[wrPtr_ff] = rdEntry;
      nxtWrPtr = !wrPtr_ff;
    end
    if (pop) begin
      nxtRdPtr = !rdPtr_ff;
    end
    nxtCnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_ff     <= '{default: '0};
      wrPtr_ff   <= 1'b0;
      rdPtr_ff   <= 1'b0;
      cnt_ff     <= 2'h0;
      rdReady_ff <= 1'b0;
    end else begin
      buf_ff     <= nxtBuf;
      wrPtr_ff   <= nxtWrPtr;
      rdPtr_ff   <= nxtRdPtr;
      cnt_ff     <= nxtCnt;
      rdReady_ff <= nxtCnt != 2'h2;
    end
  end

  // Protocol engine
  mcs_state_t  state_ff, nxtState;
  logic [2:0]  bitCnt_ff, nxtBitCnt, cmdCnt_ff, nxtCmdCnt;
  logic [7:0]  rxSh_ff, nxtRxSh, txSh_ff, nxtTxSh, txNext_ff, nxtTxNext, rxByte, crcHi_ff;
  logic [7:0]  nxtCrcHi, r1;
  logic        nxtMiso, nxtOe, spiMode_ff, nxtSpiMode, crcOn_ff, nxtCrcOn, inIdle_ff;
  logic        nxtInIdle, wrErr_ff, nxtWrErr, nxtReqValid, nxtWrValid, byteDone, cmdDone;
  logic        crcOk, collect;
  logic [1:0]  polls_ff, nxtPolls;
  logic [9:0]  blkLen_ff, nxtBlkLen, xfer_ff, nxtXfer, len_ff, nxtLen;
  logic [5:0]  cmdIdx_ff, nxtCmdIdx;
  logic [31:0] cmdArg_ff, nxtCmdArg, wrAddr_ff, nxtWrAddr;
  logic [6:0]  crc7_ff, nxtCrc7;
  logic [15:0] crc16_ff, nxtCrc16;
  logic [7:0]  nxtWrData;
  mcs_req_t    nxtReq;

  assign rxByte   = {rxSh_ff[6:0], mosiF};
  assign byteDone = rise && csLow && bitCnt_ff == 3'h7;
  assign collect  = state_ff == ST_CMD || state_ff == ST_BUSY;
  assign cmdDone  = byteDone && collect && cmdCnt_ff == `MCS_CMD_LAST;
  assign crcOk    = (spiMode_ff && !crcOn_ff) || rxByte[7:1] == crc7_ff;

  always_comb begin
    nxtState = state_ff; nxtBitCnt = bitCnt_ff; nxtRxSh = rxSh_ff; nxtTxSh = txSh_ff;
    nxtTxNext = txNext_ff; nxtMiso = cardSerialOut_ff; nxtSpiMode = spiMode_ff;
    nxtCrcOn = crcOn_ff; nxtInIdle = inIdle_ff; nxtPolls = polls_ff; nxtBlkLen = blkLen_ff;
    nxtCmdCnt = cmdCnt_ff; nxtCmdIdx = cmdIdx_ff; nxtCmdArg = cmdArg_ff; nxtCrc7 = crc7_ff;
    nxtCrc16 = crc16_ff; nxtXfer = xfer_ff; nxtLen = len_ff; nxtCrcHi = crcHi_ff;
    nxtWrErr = wrErr_ff; nxtWrAddr = wrAddr_ff; nxtReq = req_ff; nxtReqValid = 1'b0;
    nxtWrValid = 1'b0; nxtWrData = wrData_ff; pop = 1'b0;
    r1 = {7'h00, inIdle_ff};
    nxtOe = spiMode_ff && csLow;
    if (!csLow) begin
      nxtBitCnt = 3'h0;
      nxtCmdCnt = 3'h0;
    end
    if (csFall) begin
      nxtTxSh = 8'hFF;
      nxtMiso = (state_ff == ST_BUSY) ? !memBusy : 1'b1;
    end
    if (rise && csLow) begin
      nxtRxSh = rxByte;
      nxtBitCnt = 3'(bitCnt_ff + 3'h1);
    end
    if (fall && csLow) begin
      if (bitCnt_ff == 3'h0) begin
        nxtTxSh = txNext_ff;
        nxtMiso = txNext_ff[7];
      end else begin
        nxtTxSh = {txSh_ff[6:0], 1'b0};
        nxtMiso = txSh_ff[6];
      end
      if (state_ff == ST_BUSY) begin
        nxtMiso = !memBusy;
      end
    end
    if (byteDone) begin
      nxtTxNext = (state_ff == ST_BUSY) ? `MCS_BYTE_BUSY : `MCS_BYTE_IDLE;
      if (collect) begin
        case (cmdCnt_ff)
          3'h0: begin
            if (rxByte[7:6] == 2'b01) begin
              nxtCmdCnt = 3'h1;
              nxtCmdIdx = rxByte[5:0];
              nxtCrc7 = crc7Byte(7'h00, rxByte);
            end
          end
          `MCS_CMD_LAST: nxtCmdCnt = 3'h0;
          default: begin
            nxtCmdCnt = 3'(cmdCnt_ff + 3'h1);
            nxtCmdArg = {cmdArg_ff[23:0], rxByte};
            nxtCrc7 = crc7Byte(crc7_ff, rxByte);
          end
        endcase
      end
      case (state_ff)
        ST_R2: begin
          nxtTxNext = cardStatus;
          nxtState = ST_CMD;
        end
        ST_RD_WAIT: begin
          if (cnt_ff != 2'h0) begin
            if (head.err) begin
              pop = 1'b1;
              nxtTxNext = `MCS_TOK_DERR;
              nxtState = ST_CMD;
            end else begin
              nxtTxNext = `MCS_TOK_START;
              nxtCrc16 = 16'h0000;
              nxtXfer = 10'h000;
              nxtState = ST_RD_DATA;
            end
          end
        end
        ST_RD_DATA: begin
          pop = cnt_ff != 2'h0;
          nxtTxNext = head.data;
          nxtCrc16 = crc16Byte(crc16_ff, head.data);
          nxtXfer = 10'(xfer_ff + 10'h001);
          if (xfer_ff == 10'(len_ff - 10'h001)) begin
            nxtState = ST_RD_CRC1;
          end
        end
        ST_RD_CRC1: begin
          nxtTxNext = crc16_ff[15:8];
          nxtState = ST_RD_CRC2;
        end
        ST_RD_CRC2: begin
          nxtTxNext = crc16_ff[7:0];
          nxtState = ST_CMD;
        end
        ST_WR_TOKEN: begin
          if (rxByte == `MCS_TOK_START) begin
            nxtCrc16 = 16'h0000;
            nxtXfer = 10'h000;
            nxtState = ST_WR_DATA;
          end
        end
        ST_WR_DATA: begin
          nxtWrValid = 1'b1;
          nxtWrData = rxByte;
          nxtCrc16 = crc16Byte(crc16_ff, rxByte);
          nxtXfer = 10'(xfer_ff + 10'h001);
          if (xfer_ff == 10'(`MCS_BLK_MAX - 10'h001)) begin
            nxtState = ST_WR_CRC1;
          end
        end
        ST_WR_CRC1: begin
          nxtCrcHi = rxByte;
          nxtState = ST_WR_CRC2;
        end
        ST_WR_CRC2: begin
          nxtReqValid = 1'b1;
          nxtReq = '{op: OP_ABORT, idx: `MCS_CMD_WRITE, arg: wrAddr_ff, len: `MCS_BLK_MAX};
          nxtState = ST_CMD;
          if (crcOn_ff && {crcHi_ff, rxByte} != crc16_ff) begin
            nxtTxNext = `MCS_DRESP_CRC;
          end else if (wrErr_ff) begin
            nxtTxNext = `MCS_DRESP_WERR;
          end else begin
            nxtTxNext = `MCS_DRESP_OK;
            nxtReq.op = OP_WRITE;
            nxtState = ST_RESP_BUSY;
          end
        end
        ST_RESP_BUSY: begin
          nxtTxNext = memBusy ? `MCS_BYTE_BUSY : `MCS_BYTE_IDLE;
          nxtState = ST_BUSY;
        end
        ST_BUSY: begin
          if (!memBusy) begin
            nxtTxNext = `MCS_BYTE_IDLE;
            nxtState = ST_CMD;
          end
        end
        default: ;
      endcase
    end
    if (cmdDone) begin
      if (!spiMode_ff || state_ff == ST_BUSY) begin
        if (cmdIdx_ff == `MCS_CMD_RESET && crcOk) begin
          nxtSpiMode = 1'b1;
          nxtInIdle = 1'b1;
          nxtPolls = 2'h0;
          nxtTxNext = 8'h01;
          nxtState = ST_CMD;
          if (state_ff == ST_BUSY) begin
            nxtReqValid = 1'b1;
            nxtReq = '{op: OP_ABORT, idx: cmdIdx_ff, arg: cmdArg_ff, len: 10'h000};
          end
        end
      end else begin
        nxtTxNext = r1;
        if (!crcOk) begin
          nxtTxNext[`MCS_R1_CRC] = 1'b1;
        end else if (!cmdLegal(cmdIdx_ff)) begin
          nxtTxNext[`MCS_R1_ILLEGAL] = 1'b1;
        end else begin
          nxtReq = '{op: OP_CMD, idx: cmdIdx_ff, arg: cmdArg_ff, len: blkLen_ff};
          case (cmdIdx_ff)
            `MCS_CMD_RESET: begin
              nxtInIdle = 1'b1;
              nxtPolls = 2'h0;
              nxtTxNext[`MCS_R1_IDLE] = 1'b1;
            end
            `MCS_CMD_INIT: begin
              if (inIdle_ff) begin
                nxtPolls = 2'(polls_ff + 2'h1);
                nxtInIdle = nxtPolls != `MCS_INIT_POLLS;
                nxtTxNext[`MCS_R1_IDLE] = nxtInIdle;
              end
            end
            `MCS_CMD_CSD, `MCS_CMD_CID: begin
              nxtReqValid = 1'b1;
              nxtReq.op = (cmdIdx_ff == `MCS_CMD_CSD) ? OP_CSD : OP_CID;
              nxtReq.len = `MCS_REG_LEN;
              nxtLen = `MCS_REG_LEN;
              nxtState = ST_RD_WAIT;
            end
            `MCS_CMD_STATUS: nxtState = ST_R2;
            `MCS_CMD_BLKLEN: begin
              if (cmdArg_ff == 32'h0 || cmdArg_ff > 32'(`MCS_BLK_MAX)) begin
                nxtTxNext[`MCS_R1_PARAM] = 1'b1;
              end else begin
                nxtBlkLen = cmdArg_ff[9:0];
              end
            end
            `MCS_CMD_READ: begin
              if (11'({2'h0, cmdArg_ff[8:0]}) + 11'({1'b0, blkLen_ff}) > 11'h200) begin
                nxtTxNext[`MCS_R1_ADDR] = 1'b1;
              end else begin
                nxtReqValid = 1'b1;
                nxtReq.op = OP_READ;
                nxtLen = blkLen_ff;
                nxtState = ST_RD_WAIT;
              end
            end
            `MCS_CMD_WRITE: begin
              nxtWrErr = blkLen_ff != `MCS_BLK_MAX;
              nxtWrAddr = cmdArg_ff;
              nxtState = ST_WR_TOKEN;
            end
            `MCS_CMD_CRCTOG: nxtCrcOn = cmdArg_ff[0];
            `MCS_CMD_ERASE, `MCS_CMD_SETWP, `MCS_CMD_CLRWP: begin
              nxtReqValid = 1'b1;
              nxtState = ST_RESP_BUSY;
            end
            default: nxtReqValid = 1'b1;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_CMD; bitCnt_ff <= 3'h0; rxSh_ff <= 8'h00; txSh_ff <= 8'hFF;
      txNext_ff <= 8'hFF; cardSerialOut_ff <= 1'b1; cardSerialOutOe_ff <= 1'b0;
      spiMode_ff <= 1'b0; crcOn_ff <= 1'b0; inIdle_ff <= 1'b1; polls_ff <= 2'h0;
      blkLen_ff <= `MCS_BLK_MAX; cmdCnt_ff <= 3'h0; cmdIdx_ff <= 6'h00;
      cmdArg_ff <= 32'h0; crc7_ff <= 7'h00; crc16_ff <= 16'h0000; xfer_ff <= 10'h000;
      len_ff <= `MCS_BLK_MAX; crcHi_ff <= 8'h00; wrErr_ff <= 1'b0; wrAddr_ff <= 32'h0;
      req_ff <= '0; reqValid_ff <= 1'b0; wrValid_ff <= 1'b0; wrData_ff <= 8'h00;
    end else begin
      state_ff <= nxtState; bitCnt_ff <= nxtBitCnt; rxSh_ff <= nxtRxSh; txSh_ff <= nxtTxSh;
      txNext_ff <= nxtTxNext; cardSerialOut_ff <= nxtMiso; cardSerialOutOe_ff <= nxtOe;
      spiMode_ff <= nxtSpiMode; crcOn_ff <= nxtCrcOn; inIdle_ff <= nxtInIdle;
      polls_ff <= nxtPolls; blkLen_ff <= nxtBlkLen; cmdCnt_ff <= nxtCmdCnt;
      cmdIdx_ff <= nxtCmdIdx; cmdArg_ff <= nxtCmdArg; crc7_ff <= nxtCrc7;
      crc16_ff <= nxtCrc16; xfer_ff <= nxtXfer; len_ff <= nxtLen; crcHi_ff <= nxtCrcHi;
      wrErr_ff <= nxtWrErr; wrAddr_ff <= nxtWrAddr; req_ff <= nxtReq;
      reqValid_ff <= nxtReqValid; wrValid_ff <= nxtWrValid; wrData_ff <= nxtWrData;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  byte_align_a: assert property (!csLow |=> bitCnt_ff == 3'h0)
    else $error("bit count not reset by deselect");
  native_silent_a: assert property (!spiMode_ff |=> !cardSerialOutOe_ff)
    else $error("output driven in native mode");
  mode_sticky_a: assert property (spiMode_ff |=> spiMode_ff)
    else $error("SPI mode left");
  deselect_tri_a: assert property (!csLow |=> !cardSerialOutOe_ff)
    else $error("output driven while deselected");
  busy_low_a: assert property (state_ff == ST_BUSY && memBusy && fall && csLow
    |=> !cardSerialOut_ff) else $error("busy not shown as low");
  cmd_answer_a: assert property (cmdDone && spiMode_ff && state_ff == ST_CMD
    |=> !txNext_ff[7] ##1 !txNext_ff[7] [*2]) else $error("no response queued");
  crc_start_off_a: assert property ($rose(spiMode_ff) |-> !crcOn_ff)
    else $error("CRC on at SPI entry");
  write_len_a: assert property (state_ff == ST_WR_DATA && byteDone
    && xfer_ff == 10'h1FF |=> state_ff == ST_WR_CRC1) else $error("bad block length");
  data_err_a: assert property (state_ff == ST_RD_WAIT && byteDone && cnt_ff != 2'h0
    && head.err |=> txNext_ff == `MCS_TOK_DERR) else $error("no data-error token");
  reset_abort_a: assert property (cmdDone && state_ff == ST_BUSY && crcOk
    && cmdIdx_ff == `MCS_CMD_RESET |=> reqValid_ff && req_ff.op == OP_ABORT)
    else $error("reset did not abort programming");
  enter_spi_c: cover property ($rose(spiMode_ff));
  read_done_c: cover property (state_ff == ST_RD_CRC2 && byteDone);
  write_prog_c: cover property (reqValid_ff && req_ff.op == OP_WRITE);
  buf_full_c: cover property (cnt_ff == 2'h2);
endmodule

// [verification/mcs_host_model.sv]
`timescale 1ns/1ns
module mcs_host_model (
  input  wire logic core_clk,
  input  wire logic cardSerialOut,
  input  wire logic cardSerialOutOe,
  output logic      sclk,
  output logic      selN,
  output logic      mosi
);
  logic lastOut;
  wire  hostIn;
  // Released line shows the inverse of the last driven bit
  assign hostIn = cardSerialOutOe ? cardSerialOut : ~lastOut;
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    mosi = 1'b1;
    lastOut = 1'b1;
  end
  always @(posedge core_clk) begin
    if (cardSerialOutOe) lastOut <= cardSerialOut;
  end
  // Whole bytes MSB first, data set while clock low, sampled at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= tx[i];
      repeat (8) @(posedge core_clk);
      rx[i] = hostIn;
      sclk <= 1'b1;
      repeat (8) @(posedge core_clk);
    end
    sclk <= 1'b0;
    mosi <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  // Every transaction opens with select low
  task automatic select_card();
    selN <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  // Eight spare clocks before the clock stops
  task automatic release_card();
    logic [7:0] d;
    xfer(8'hFF, d);
    selN <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// [verification/memory_card_spi_protocol_test.sv]
`timescale 1ns/1ns
`include "mcs_map.svh"
module memory_card_spi_protocol_test;
  import mcs_pkg::*;
  localparam int BUSY_CYC = 3000;
  logic       core_clk, arst_n, sclk, selN, mosi, outBit, outOe;
  logic       rdValid, rdReady_ff, reqValid_ff, wrValid_ff, memBusy, errNext;
  logic [7:0] wrData_ff, cardStatus, r;
  mcs_rd_t    rdEntry;
  mcs_req_t   req_ff;
  mcs_op_t    lastOp;
  int         bad_count, checked, busyCnt, blkLen;
  mcs_rd_t    rdQ[$];
  logic [7:0] expQ[$], wrQ[$];

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  mcs_spi_card uut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .selN(selN),
    .cardSerialIn(mosi), .cardSerialOut_ff(outBit), .cardSerialOutOe_ff(outOe),
    .rdEntry(rdEntry), .rdValid(rdValid), .rdReady_ff(rdReady_ff), .req_ff(req_ff),
    .reqValid_ff(reqValid_ff), .wrData_ff(wrData_ff), .wrValid_ff(wrValid_ff),
    .memBusy(memBusy), .cardStatus(cardStatus));
  mcs_host_model host (.core_clk(core_clk), .cardSerialOut(outBit),
    .cardSerialOutOe(outOe), .sclk(sclk), .selN(selN), .mosi(mosi));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [7:0] crc,
                     input logic [7:0] exp);
    logic [7:0] d;
    host.xfer({2'b01, idx}, d);
    for (int i = 0; i < 4; i++) host.xfer(arg[31-8*i -: 8], d);
    host.xfer(crc, d);
    host.xfer(8'hFF, r);
    check("command answer", 16'(exp), 16'(r));
  endtask
  task automatic wait_byte(input logic [7:0] skip);
    int k;
    k = 0;
    while (r === skip && k < 40) begin
      host.xfer(8'hFF, r);
      k++;
    end
    if (r === skip) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic read_block(input int n, input logic err);
    logic [15:0] c;
    logic [7:0]  e;
    c = 16'h0000;
    r = 8'hFF;
    wait_byte(8'hFF);
    check("start token", err ? 16'h0001 : 16'h00FE, 16'(r));
    for (int i = 0; i < (err ? 0 : n + 2); i++) begin
      host.xfer(8'hFF, r);
      e = (i < n) ? expQ.pop_front() : ((i == n) ? c[15:8] : c[7:0]);
      if (i < n) c = crc16(c, e);
      check("read byte", 16'(e), 16'(r));
    end
  endtask

  // Store model: feeds the read buffer and reports busy after commits
  always @(posedge core_clk) begin
    logic [7:0] d;
    if (rdValid && rdReady_ff) void'(rdQ.pop_front());
    if (reqValid_ff) begin
      lastOp = req_ff.op;
      if (req_ff.op inside {OP_READ, OP_CSD, OP_CID}) begin
        check("read length", (req_ff.op == OP_READ) ? 16'(blkLen) : 16'd16, 16'(req_ff.len));
        for (int i = 0; i < (errNext ? 1 : int'(req_ff.len)); i++) begin
          d = 8'($urandom);
          rdQ.push_back({errNext, d});
          if (!errNext) expQ.push_back(d);
        end
      end
      if (req_ff.op == OP_WRITE) check("commit address", 16'h0400, 16'(req_ff.arg));
      if (req_ff.op == OP_WRITE || (req_ff.op == OP_CMD && req_ff.idx == 6'h26)) busyCnt = BUSY_CYC;
      if (req_ff.op == OP_ABORT) busyCnt = 0;
    end
    if (wrValid_ff) check("write byte", 16'(wrQ.pop_front()), 16'(wrData_ff));
    if (busyCnt > 0) busyCnt--;
    memBusy <= busyCnt > 0;
    rdValid <= rdQ.size() > 0;
    rdEntry <= (rdQ.size() > 0) ? rdQ[0] : {1'b0, 8'($urandom)};
  end

  initial begin
    logic [15:0] c;
    logic [7:0]  d;
    arst_n = 1'b0;
    rdValid = 1'b0;
    rdEntry = '0;
    memBusy = 1'b0;
    cardStatus = 8'h00;
    bad_count = 0;
    checked = 0;
    busyCnt = 0;
    blkLen = 512;
    errNext = 1'b0;
    lastOp = OP_CMD;
    void'($urandom(37576));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    host.select_card();
    // Silent card: the released line reads as the inverse of its idle high
    cmd(`MCS_CMD_INIT, 32'h0, 8'hFF, 8'h00);
    check("native output enable", 16'h0000, 16'(outOe));
    host.release_card();
    $display("test native_silent done");
    for (int i = 0; i < 10; i++) host.xfer(8'hFF, r);
    host.select_card();
    cmd(`MCS_CMD_RESET, 32'h0, 8'h95, 8'h01);
    cmd(`MCS_CMD_INIT, 32'h0, 8'hFF, 8'h01);
    cmd(`MCS_CMD_INIT, 32'h0, 8'hFF, 8'h00);
    cmd(6'h06, 32'h0, 8'hFF, 8'h04);
    cardStatus <= 8'($urandom);
    cmd(`MCS_CMD_STATUS, 32'h0, 8'hFF, 8'h00);
    host.xfer(8'hFF, r);
    check("status byte", 16'(cardStatus), 16'(r));
    $display("test init_status done");
    cmd(`MCS_CMD_WRITE, 32'h400, 8'hFF, 8'h00);
    host.xfer(8'hFE, r);
    c = 16'h0000;
    for (int i = 0; i < 512; i++) begin
      d = 8'($urandom);
      wrQ.push_back(d);
      c = crc16(c, d);
      host.xfer(d, r);
    end
    host.xfer(c[15:8], r);
    host.xfer(c[7:0], r);
    host.xfer(8'hFF, r);
    check("data response", 16'h0005, 16'(r));
    host.xfer(8'hFF, r);
    check("busy byte", 16'h0000, 16'(r));
    check("commit op", 16'(OP_WRITE), 16'(lastOp));
    check("bytes left", 16'h0000, 16'(wrQ.size()));
    host.release_card();
    check("deselected enable", 16'h0000, 16'(outOe));
    host.select_card();
    cmd(`MCS_CMD_STATUS, 32'h0, 8'hFF, 8'h00);
    wait_byte(8'h00);
    // Busy may end inside a byte, so the first non-busy byte can be partial
    if (r !== 8'hFF) host.xfer(8'hFF, r);
    check("busy released", 16'h00FF, 16'(r));
    $display("test write_busy done");
    blkLen = 4;
    cmd(`MCS_CMD_BLKLEN, 32'h4, 8'hFF, 8'h00);
    cmd(`MCS_CMD_READ, 32'h200, 8'hFF, 8'h00);
    read_block(4, 1'b0);
    cmd(`MCS_CMD_CSD, 32'h0, 8'hFF, 8'h00);
    read_block(16, 1'b0);
    cmd(`MCS_CMD_CID, 32'h0, 8'hFF, 8'h00);
    read_block(16, 1'b0);
    errNext = 1'b1;
    cmd(`MCS_CMD_READ, 32'h0, 8'hFF, 8'h00);
    read_block(4, 1'b1);
    errNext = 1'b0;
    cmd(`MCS_CMD_READ, 32'h1FE, 8'hFF, 8'h20);
    cmd(`MCS_CMD_BLKLEN, 32'h0, 8'hFF, 8'h40);
    $display("test reads done");
    cmd(`MCS_CMD_ERASE, 32'h0, 8'hFF, 8'h00);
    host.xfer(8'hFF, r);
    check("erase busy", 16'h0000, 16'(r));
    cmd(`MCS_CMD_RESET, 32'h0, 8'h95, 8'h01);
    check("abort op", 16'(OP_ABORT), 16'(lastOp));
    cmd(`MCS_CMD_CRCTOG, 32'h1, 8'hFF, 8'h01);
    cmd(`MCS_CMD_INIT, 32'h0, 8'h00, 8'h09);
    host.release_card();
    $display("test erase_abort_crc done");
    tally_and_finish();
  end
endmodule
